/* degd_pkg.sv */
// package: constants, register map and types of the data eeprom write guard
package degd_pkg;
    // register byte offsets on the apb bus, one aligned word each
    localparam logic [7:0] OFS_IRQ_GLOBAL = 8'h00;
    localparam logic [7:0] OFS_ADDRESS    = 8'h04;
    localparam logic [7:0] OFS_DATA       = 8'h08;
    localparam logic [7:0] OFS_UNLOCK_KEY = 8'h0c;
    localparam logic [7:0] OFS_CONTROL    = 8'h10;
    localparam logic [7:0] OFS_PRIORITY2  = 8'h14;
    localparam logic [7:0] OFS_FLAGS2     = 8'h18;
    localparam logic [7:0] OFS_ENABLES2   = 8'h1c;

    // nvm_control_reg bit positions
    localparam int CTL_MEM_SPACE   = 7;
    localparam int CTL_CFG_SPACE   = 6;
    localparam int CTL_ABORTED     = 3;
    localparam int CTL_PERMIT      = 2;
    localparam int CTL_GO          = 1;
    localparam int CTL_READ        = 0;
    // interrupt_global_control bit positions
    localparam int IGC_GLOBAL_GATE = 7;
    localparam int IGC_PERIPH_GATE = 6;
    // position of the done flag, enable and priority in the peripheral registers
    localparam int PER_NVM_DONE    = 4;

    // values after reset
    localparam logic [7:0] RST_IRQ_GLOBAL = 8'h00;
    localparam logic [7:0] RST_ADDRESS    = 8'h00;
    localparam logic [7:0] RST_DATA       = 8'h00;
    localparam logic       RST_PRIORITY   = 1'b1;

    // unlock key bytes
    localparam logic [7:0] KEY_FIRST  = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'haa;

    // timing
    localparam longint CLK_HZ            = 20000000;
    localparam longint PWRT_MS           = 72;
    localparam longint PWRT_CYCLES       = (PWRT_MS * CLK_HZ) / 1000;
    localparam longint CELL_WRITE_US     = 4000;
    localparam longint CELL_WRITE_CYCLES = (CELL_WRITE_US * CLK_HZ) / 1000000;

    // unlock sequence tracker, one-hot
    typedef enum logic [2:0] {
        KEY_IDLE  = 3'b001,
        KEY_GOT55 = 3'b010,
        KEY_ARMED = 3'b100
    } degd_key_t;

    // external (programming side) access request
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] addr;
        logic [7:0] wdata;
    } degd_ext_req_t;

    // external access answer
    typedef struct packed {
        logic       ack;
        logic       denied;
        logic [7:0] rdata;
    } degd_ext_rsp_t;
endpackage

/* degd_cell_array.sv */
// byte-wide cell array with registered read data
`timescale 1ns/100ps
module degd_cell_array #(
    parameter int ADDR_W = 8,
    parameter int DATA_W = 8
) (
    // clock
    input  wire logic              clk_sys,
    // access port
    input  wire logic              we,
    input  wire logic              re,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wdata,
    output logic      [DATA_W-1:0] rdata_q
);
    logic [DATA_W-1:0] cells [0:(1<<ADDR_W)-1];

    // array content is not reset: it models nonvolatile storage
    always_ff @(posedge clk_sys) begin
        if (we) begin
            cells[addr] <= wdata;
        end
        if (re) begin
            rdata_q <= cells[addr];
        end
    end
endmodule

/* degd_write_guard.sv */
// data eeprom controller: apb registers, unlock guard, write timing, code protect, completion interrupt
//
// Summary of operation
// - every power-up clears the program permit bit.
// - core writes stay blocked while the power-up timer of 72 ms runs; external writes are not held by it.
// - write starts only after 55h, then AAh to key port, then go bit.
// - write completion raises an interrupt request that can wake the core.
// - go bit reads set for the whole write cycle.
// - read strobe loads the byte at the held address into the data register.
// - external access is refused while either code-protect bit is set.
// - the core reaches the array whatever the code-protect bits say.
// - every core access moves exactly one byte at the held address; external access uses its own address.
// - the key port has no storage; it only tracks the key sequence.
// - end of write clears go in hardware and sets the done flag.
// - go is refused unless permit was set by an earlier write.
// - control, address and data ignore writes while a write runs.
// - read byte is in the data register by the next access.
//
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/100ps
module degd_write_guard
    import degd_pkg::*;
#(
    parameter int     ADDR_W      = 8,
    parameter longint PWRT_CYC    = PWRT_CYCLES,
    parameter longint WRITE_CYC   = CELL_WRITE_CYCLES
) (
    // clock and power-on / brown-out reset
    input  wire logic                  clk_sys,
    input  wire logic                  srst,
    // apb slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic                       pready,
    output logic      [31:0]           prdata,
    output logic                       pslverr,
    // code-protect configuration bits for the data array
    input  wire logic [1:0]            cp_data,
    // external programming access
    input  wire degd_pkg::degd_ext_req_t ext_req,
    output degd_pkg::degd_ext_rsp_t    ext_rsp,
    // interrupt and wake
    output logic                       nvm_irq,
    output logic                       nvm_irq_high,
    output logic                       nvm_wake
);
    import degd_pkg::*;

    localparam int TW = 32;

    function automatic logic is_reg(input logic [7:0] a, input logic [7:0] ofs);
        is_reg = (a == ofs);
    endfunction

    // register state
    logic [7:0]  igc_q, igc_d;
    logic [7:0]  addr_q, addr_d;
    logic [7:0]  data_q, data_d;
    logic        msel_q, msel_d;
    logic        csel_q, csel_d;
    logic        permit_q, permit_d;
    logic        go_q, go_d;
    logic        rd_pend_q, rd_pend_d;
    logic        done_flag_q, done_flag_d;
    logic        done_en_q, done_en_d;
    logic        done_prio_q, done_prio_d;
    degd_key_t   key_q, key_d;
    logic [TW-1:0] pwrt_q, pwrt_d;
    logic [TW-1:0] wcnt_q, wcnt_d;
    logic        ext_pend_q, ext_pend_d;
    degd_ext_rsp_t rsp_q, rsp_d;
    logic [31:0] prdata_q, prdata_d;
    logic        slverr_q, slverr_d;

    // array port
    logic              mem_we;
    logic              mem_re;
    logic [ADDR_W-1:0] mem_addr;
    logic [7:0]        mem_wdata;
    logic [7:0]        mem_rdata;

    logic        bus_setup;
    logic        bus_wr;
    logic        mapped;
    logic        start_write;
    logic        pwrt_done;
    logic        done_evt;

    degd_cell_array #(
        .ADDR_W (ADDR_W),
        .DATA_W (8)
    ) u_cells (
        .clk_sys (clk_sys),
        .we      (mem_we),
        .re      (mem_re),
        .addr    (mem_addr),
        .wdata   (mem_wdata),
        .rdata_q (mem_rdata)
    );

    // zero wait states: answers are formed in the setup cycle and shown in the access cycle
    assign pready    = 1'b1;
    assign prdata    = prdata_q;
    assign pslverr   = slverr_q;
    assign bus_setup = psel && !penable;
    assign bus_wr    = psel && penable && pwrite && mapped;
    assign pwrt_done = (pwrt_q == '0);
    assign ext_rsp   = rsp_q;

    assign mapped = is_reg(paddr, OFS_IRQ_GLOBAL) || is_reg(paddr, OFS_ADDRESS) ||
                    is_reg(paddr, OFS_DATA) || is_reg(paddr, OFS_UNLOCK_KEY) ||
                    is_reg(paddr, OFS_CONTROL) || is_reg(paddr, OFS_PRIORITY2) ||
                    is_reg(paddr, OFS_FLAGS2) || is_reg(paddr, OFS_ENABLES2);

    // old permit value, armed key, both select bits written clear, idle, timer expired
    assign start_write = bus_wr && is_reg(paddr, OFS_CONTROL) && pwdata[CTL_GO] &&
                         permit_q && (key_q == KEY_ARMED) && !go_q && pwrt_done &&
                         !pwdata[CTL_MEM_SPACE] && !pwdata[CTL_CFG_SPACE];

    assign done_evt = go_q && (wcnt_q == TW'(1));

    // interrupt outputs: irq and wake both ignore the global gate, so sleep can end on completion
    assign nvm_wake     = done_flag_q && done_en_q;
    assign nvm_irq      = done_flag_q && done_en_q;
    assign nvm_irq_high = done_flag_q && done_en_q && done_prio_q;

    // array port arbitration: write start, then core read, then external access
    always_comb begin
        mem_we    = 1'b0;
        mem_re    = 1'b0;
        mem_addr  = addr_q[ADDR_W-1:0];
        mem_wdata = data_q;
        if (start_write) begin
            mem_we = 1'b1;
        end else if (bus_wr && is_reg(paddr, OFS_CONTROL) && pwdata[CTL_READ] && !go_q &&
                     !pwdata[CTL_MEM_SPACE] && !pwdata[CTL_CFG_SPACE]) begin
            mem_re = 1'b1;
        end else if (ext_req.valid && !ext_pend_q && !rsp_q.ack && !go_q && (cp_data == 2'b00)) begin
            mem_addr  = ext_req.addr[ADDR_W-1:0];
            mem_wdata = ext_req.wdata;
            mem_we    = ext_req.write;
            mem_re    = !ext_req.write;
        end
    end

    // register next values
    always_comb begin
        igc_d       = igc_q;
        addr_d      = addr_q;
        data_d      = data_q;
        msel_d      = msel_q;
        csel_d      = csel_q;
        permit_d    = permit_q;
        go_d        = go_q;
        rd_pend_d   = 1'b0;
        done_flag_d = done_flag_q;
        done_en_d   = done_en_q;
        done_prio_d = done_prio_q;
        key_d       = key_q;
        pwrt_d      = pwrt_q;
        wcnt_d      = wcnt_q;
        ext_pend_d  = 1'b0;
        rsp_d       = '0;
        rsp_d.rdata = rsp_q.rdata;
        prdata_d    = prdata_q;
        slverr_d    = 1'b0;

        if (!pwrt_done) begin
            pwrt_d = pwrt_q - TW'(1);
        end

        // key tracker: any mapped write that is not the next step or a fresh 55h drops the sequence
        if (bus_wr) begin
            if (is_reg(paddr, OFS_UNLOCK_KEY)) begin
                if (pwdata[7:0] == KEY_FIRST) begin
                    key_d = KEY_GOT55;
                end else if (pwdata[7:0] == KEY_SECOND && key_q == KEY_GOT55) begin
                    key_d = KEY_ARMED;
                end else begin
                    key_d = KEY_IDLE;
                end
            end else begin
                key_d = KEY_IDLE;
            end
        end

        // software writes; holding registers frozen during a write cycle
        if (bus_wr) begin
            if (is_reg(paddr, OFS_IRQ_GLOBAL)) begin
                igc_d = pwdata[7:0];
            end
            if (!go_q) begin
                if (is_reg(paddr, OFS_ADDRESS)) begin
                    addr_d = pwdata[7:0];
                end
                if (is_reg(paddr, OFS_DATA)) begin
                    data_d = pwdata[7:0];
                end
                if (is_reg(paddr, OFS_CONTROL)) begin
                    msel_d   = pwdata[CTL_MEM_SPACE];
                    csel_d   = pwdata[CTL_CFG_SPACE];
                    permit_d = pwdata[CTL_PERMIT];
                    // only a core strobe may reload the data register, never an external read sharing the port
                    rd_pend_d = mem_re && pwdata[CTL_READ] && !pwdata[CTL_MEM_SPACE] && !pwdata[CTL_CFG_SPACE];
                end
            end
            if (is_reg(paddr, OFS_FLAGS2) && pwdata[PER_NVM_DONE]) begin
                done_flag_d = 1'b0;
            end
            if (is_reg(paddr, OFS_ENABLES2)) begin
                done_en_d = pwdata[PER_NVM_DONE];
            end
            if (is_reg(paddr, OFS_PRIORITY2)) begin
                done_prio_d = pwdata[PER_NVM_DONE];
            end
        end

        // read byte lands one cycle after the strobe, before the next access ends
        if (rd_pend_q) begin
            data_d = mem_rdata;
        end

        if (start_write) begin
            go_d   = 1'b1;
            wcnt_d = TW'(WRITE_CYC);
        end else if (go_q) begin
            wcnt_d = wcnt_q - TW'(1);
            if (done_evt) begin
                go_d = 1'b0;
            end
        end

        // completion sets the flag; set wins over a clear in the same cycle
        if (done_evt) begin
            done_flag_d = 1'b1;
        end

        // external access: refused at once while either protect bit is set
        if (ext_pend_q) begin
            rsp_d.ack   = 1'b1;
            rsp_d.rdata = mem_rdata;
        end else if (ext_req.valid && !rsp_q.ack && (cp_data != 2'b00)) begin
            rsp_d.ack    = 1'b1;
            rsp_d.denied = 1'b1;
        end else if (mem_we && !start_write) begin
            rsp_d.ack = 1'b1;
        end else if (mem_re && !(bus_wr && is_reg(paddr, OFS_CONTROL))) begin
            ext_pend_d = 1'b1;
        end

        // read data and error are formed in the setup cycle
        if (bus_setup) begin
            prdata_d = '0;
            slverr_d = !mapped;
            if (!pwrite) begin
                if (is_reg(paddr, OFS_IRQ_GLOBAL)) begin
                    prdata_d[7:0] = igc_q;
                end
                if (is_reg(paddr, OFS_ADDRESS)) begin
                    prdata_d[7:0] = addr_q;
                end
                if (is_reg(paddr, OFS_DATA)) begin
                    prdata_d[7:0] = rd_pend_q ? mem_rdata : data_q;
                end
                if (is_reg(paddr, OFS_CONTROL)) begin
                    prdata_d[CTL_MEM_SPACE] = msel_q;
                    prdata_d[CTL_CFG_SPACE] = csel_q;
                    prdata_d[CTL_PERMIT]    = permit_q;
                    prdata_d[CTL_GO]        = go_q;
                    prdata_d[CTL_READ]      = rd_pend_q;
                end
                if (is_reg(paddr, OFS_FLAGS2)) begin
                    prdata_d[PER_NVM_DONE] = done_flag_q;
                end
                if (is_reg(paddr, OFS_ENABLES2)) begin
                    prdata_d[PER_NVM_DONE] = done_en_q;
                end
                if (is_reg(paddr, OFS_PRIORITY2)) begin
                    prdata_d[PER_NVM_DONE] = done_prio_q;
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            igc_q       <= RST_IRQ_GLOBAL;
            addr_q      <= RST_ADDRESS;
            data_q      <= RST_DATA;
            msel_q      <= 1'b0;
            csel_q      <= 1'b0;
            permit_q    <= 1'b0;
            go_q        <= 1'b0;
            rd_pend_q   <= 1'b0;
            done_flag_q <= 1'b0;
            done_en_q   <= 1'b0;
            done_prio_q <= RST_PRIORITY;
            key_q       <= KEY_IDLE;
            pwrt_q      <= TW'(PWRT_CYC);
            wcnt_q      <= '0;
            ext_pend_q  <= 1'b0;
            rsp_q       <= '0;
            prdata_q    <= '0;
            slverr_q    <= 1'b0;
        end else begin
            igc_q       <= igc_d;
            addr_q      <= addr_d;
            data_q      <= data_d;
            msel_q      <= msel_d;
            csel_q      <= csel_d;
            permit_q    <= permit_d;
            go_q        <= go_d;
            rd_pend_q   <= rd_pend_d;
            done_flag_q <= done_flag_d;
            done_en_q   <= done_en_d;
            done_prio_q <= done_prio_d;
            key_q       <= key_d;
            pwrt_q      <= pwrt_d;
            wcnt_q      <= wcnt_d;
            ext_pend_q  <= ext_pend_d;
            rsp_q       <= rsp_d;
            prdata_q    <= prdata_d;
            slverr_q    <= slverr_d;
        end
    end
endmodule

/* degd_checker.sv */
// checker: port-level assertions for the write guard
`timescale 1ns/100ps
module degd_checker (
    // clock and reset
    input wire logic                    clk_sys,
    input wire logic                    srst,
    // apb
    input wire logic                    psel,
    input wire logic                    penable,
    input wire logic                    pwrite,
    input wire logic [7:0]              paddr,
    input wire logic                    pready,
    input wire logic [31:0]             prdata,
    // code protect and external access
    input wire logic [1:0]              cp_data,
    input wire degd_pkg::degd_ext_req_t ext_req,
    input wire degd_pkg::degd_ext_rsp_t ext_rsp,
    // interrupt
    input wire logic                    nvm_irq,
    input wire logic                    nvm_irq_high,
    input wire logic                    nvm_wake
);
    import degd_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);

    property p_wake; nvm_wake == nvm_irq; endproperty
    property p_high; nvm_irq_high |-> nvm_irq; endproperty
    property p_ready; psel && penable |-> pready; endproperty
    property p_key; psel && penable && !pwrite && paddr == OFS_UNLOCK_KEY |-> prdata == 32'h0; endproperty
    property p_byte; psel && penable && !pwrite |-> prdata[31:8] == 24'h0; endproperty
    property p_ack; ext_rsp.ack |=> !ext_rsp.ack; endproperty
    // a protect bit set for the whole request must end in a refusal
    property p_deny; ext_rsp.ack && $past(cp_data) != 2'h0 && $past(cp_data, 2) != 2'h0 |-> ext_rsp.denied;
    endproperty
    property p_allow;
        ext_rsp.ack && $past(cp_data) == 2'h0 && $past(cp_data, 2) == 2'h0 && $past(cp_data, 3) == 2'h0
        |-> !ext_rsp.denied;
    endproperty
    property p_deny_ack; ext_rsp.denied |-> ext_rsp.ack; endproperty

    a_wake: assert property (p_wake) else $error("wake differs from irq");
    a_high: assert property (p_high) else $error("high irq without irq");
    a_ready: assert property (p_ready) else $error("access without ready");
    a_key: assert property (p_key) else $error("key port returned data");
    a_byte: assert property (p_byte) else $error("upper read bits set");
    a_ack: assert property (p_ack) else $error("ack longer than one cycle");
    a_deny: assert property (p_deny) else $error("protected access granted");
    a_allow: assert property (p_allow) else $error("unprotected access denied");
    a_deny_ack: assert property (p_deny_ack) else $error("denied without ack");

    c_deny: cover property (ext_rsp.denied);
    c_grant: cover property (ext_rsp.ack && !ext_rsp.denied);
    c_irq: cover property ($rose(nvm_irq));
endmodule

bind degd_write_guard degd_checker u_degd_checker (.clk_sys, .srst, .psel, .penable, .pwrite, .paddr, .pready,
    .prdata, .cp_data, .ext_req, .ext_rsp, .nvm_irq, .nvm_irq_high, .nvm_wake);

/* degd_ext_prog.sv */
// partner model: external programming port master
`timescale 1ns/100ps
module degd_ext_prog (
    // clock
    input  wire logic                    clk_sys,
    // command from the bench
    input  wire logic                    start,
    input  wire logic                    write,
    input  wire logic [7:0]              addr,
    input  wire logic [7:0]              wdata,
    // port to the guard
    input  wire degd_pkg::degd_ext_rsp_t ext_rsp,
    output degd_pkg::degd_ext_req_t      ext_req,
    output logic                         busy
);
    import degd_pkg::*;
    initial ext_req = '0;
    initial busy = 1'b0;
    // request held until ack; released lines flip so stale values never look live
    always @(posedge clk_sys) begin
        if (start && !busy) begin
            ext_req <= '{1'b1, write, addr, wdata};
            busy <= 1'b1;
        end else if (busy && ext_rsp.ack) begin
            ext_req <= '{1'b0, ~ext_req.write, ~ext_req.addr, ~ext_req.wdata};
            busy <= 1'b0;
        end
    end
endmodule

/* test_degd_write_guard.sv */
// testbench: apb and external access sequences against the write guard
`timescale 1ns/100ps
module test_degd_write_guard;
    import degd_pkg::*;
    localparam logic [7:0] K = OFS_UNLOCK_KEY;
    localparam logic [7:0] C = OFS_CONTROL;
    logic          clk_sys = 1'b0;
    logic          srst = 1'b1;
    logic          psel = 1'b0;
    logic          penable = 1'b0;
    logic          pwrite = 1'b0;
    logic [7:0]    paddr = 8'h00;
    logic [31:0]   pwdata = 32'h0;
    logic [1:0]    cp_data = 2'h0;
    logic          xs = 1'b0;
    logic          xw = 1'b0;
    logic [7:0]    xa = 8'h00;
    logic [7:0]    xd = 8'h00;
    logic          pready, pslverr, nvm_irq, nvm_irq_high, nvm_wake, e;
    logic [31:0]   prdata;
    degd_ext_req_t ext_req;
    degd_ext_rsp_t ext_rsp;
    logic [7:0]    q;
    int            fails = 0;
    int            n_checks = 0;
    int            i;
    logic [7:0]    rst_v [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00};
    // unlock attempts, three writes each, all broken except the last (control 00h, 55h, AAh), which arms the key but leaves permit clear before go
    logic [7:0]    sa [15] = '{K, OFS_DATA, K, K, K, K, K, K, OFS_ADDRESS, K, K, K, C, K, K};
    logic [7:0]    sd [15] = '{8'h55, 8'h11, 8'haa, 8'haa, 8'haa, 8'h55, 8'h55, 8'haa, 8'h03,
                               8'h55, 8'hab, 8'haa, 8'h00, 8'h55, 8'haa};

    degd_write_guard #(.PWRT_CYC(20), .WRITE_CYC(10)) u_degd_write_guard (.clk_sys, .srst, .psel, .penable,
        .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .cp_data, .ext_req, .ext_rsp, .nvm_irq,
        .nvm_irq_high, .nvm_wake);
    degd_ext_prog u_degd_ext_prog (.clk_sys, .start(xs), .write(xw), .addr(xa), .wdata(xd), .ext_rsp, .ext_req,
        .busy());

    always #25 clk_sys = ~clk_sys;

    task automatic ck(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        q = prdata[7:0];
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rc(input logic [7:0] a, input logic [7:0] x);
        apb(1'b0, a, 8'h00);
        ck(q, x);
    endtask

    task automatic ext(input logic w, input logic [7:0] a, input logic [7:0] d, input logic dn, input logic [7:0] x);
        xs <= 1'b1;
        xw <= w;
        xa <= a;
        xd <= d;
        @(posedge clk_sys);
        xs <= 1'b0;
        do @(posedge clk_sys); while (ext_rsp.ack !== 1'b1);
        ck({7'h00, ext_rsp.denied}, {7'h00, dn});
        if (!w && !dn) ck(ext_rsp.rdata, x);
    endtask

    task automatic end_sim;
        $display("checks=%0d fails=%0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // the sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk_sys);
        fails++;
        end_sim;
    end

    initial begin
        repeat (8) @(posedge clk_sys);
        srst <= 1'b0;
        @(posedge clk_sys);
        for (i = 0; i < 8; i++) rc(8'(i * 4), rst_v[i]);
        apb(1'b0, 8'h20, 8'h00);
        ck({7'h00, e}, 8'h01);
        wr(OFS_ADDRESS, 8'h03);
        wr(OFS_DATA, 8'ha5);
        wr(C, 8'h04);
        wr(OFS_ENABLES2, 8'h10);
        wr(K, KEY_FIRST);
        wr(K, KEY_SECOND);
        wr(C, 8'h06);
        rc(C, 8'h06);
        wr(OFS_ADDRESS, 8'h07);
        rc(OFS_ADDRESS, 8'h03);
        q = 8'h02;
        for (i = 0; i < 40 && q[CTL_GO] !== 1'b0; i++) apb(1'b0, C, 8'h00);
        ck(q, 8'h04);
        rc(OFS_FLAGS2, 8'h10);
        ck({6'h00, nvm_irq_high, nvm_wake}, 8'h03);
        wr(OFS_PRIORITY2, 8'h00);
        ck({6'h00, nvm_irq_high, nvm_irq}, 8'h01);
        wr(OFS_ENABLES2, 8'h00);
        ck({7'h00, nvm_irq}, 8'h00);
        wr(OFS_ENABLES2, 8'h10);
        ck({7'h00, nvm_irq}, 8'h01);
        wr(OFS_FLAGS2, 8'h10);
        ck({7'h00, nvm_irq}, 8'h00);
        wr(OFS_DATA, 8'h00);
        wr(C, 8'h05);
        rc(OFS_DATA, 8'ha5);
        ext(1'b1, 8'h09, 8'h3c, 1'b0, 8'h00);
        ext(1'b0, 8'h09, 8'h00, 1'b0, 8'h3c);
        for (i = 1; i < 4; i++) begin
            cp_data <= 2'(i);
            ext(1'b1, 8'h09, 8'hff, 1'b1, 8'h00);
            ext(1'b0, 8'h09, 8'h00, 1'b1, 8'h00);
        end
        wr(OFS_ADDRESS, 8'h09);
        wr(C, 8'h05);
        rc(OFS_DATA, 8'h3c);
        cp_data <= 2'h0;
        for (i = 0; i < 15; i += 3) begin
            wr(sa[i], sd[i]);
            wr(sa[i + 1], sd[i + 1]);
            wr(sa[i + 2], sd[i + 2]);
            wr(C, 8'h06);
            rc(C, 8'h04);
        end
        // armed key but the go write points at program memory: no cycle may start
        wr(K, KEY_FIRST);
        wr(K, KEY_SECOND);
        wr(C, 8'h86);
        rc(C, 8'h84);
        rc(OFS_FLAGS2, 8'h00);
        // second reset in mid-run: permit must drop and the timer must run again
        srst <= 1'b1;
        repeat (8) @(posedge clk_sys);
        srst <= 1'b0;
        @(posedge clk_sys);
        rc(C, 8'h00);
        wr(C, 8'h04);
        wr(K, KEY_FIRST);
        wr(K, KEY_SECOND);
        wr(C, 8'h06);
        rc(C, 8'h04);
        end_sim;
    end
endmodule
